// >>> common/cc_role_defines.svh
/*
 Timing counts, strap thresholds and register layout for the CC role block.
 Assumes a 40 MHz clock; included by its bare name.
*/
`ifndef CC_ROLE_DEFINES_SVH
`define CC_ROLE_DEFINES_SVH

`define CLK_MHZ             40
`define SWAP_DETECT_NS      60
`define SWAP_DETECT_CYC     ((`SWAP_DETECT_NS * `CLK_MHZ + 999) / 1000)
`define DETACH_DEBOUNCE_US  100
`define DETACH_DEBOUNCE_CYC (`DETACH_DEBOUNCE_US * `CLK_MHZ)
`define TOGGLE_HALF_US      35000
`define TOGGLE_HALF_CYC     (`TOGGLE_HALF_US * `CLK_MHZ)
`define SAR_BITS            8
`define SAR_PHASE_LAST      2'h3
`define STRAP_LIM0          8'h05
`define STRAP_LIM1          8'h12
`define STRAP_LIM2          8'h24
`define STRAP_LIM3          8'h3C
`define STRAP_LIM4          8'h5D
`define STRAP_LIM5          8'hB4
`define STRAP_LIM6          8'hE7
`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h1
`define ADDR_STRAP          4'h2
`define ADDR_SAR            4'h3
`define ADDR_MUX            4'h4
`define CTRL_ROLE_LSB       0
`define CTRL_FRS_EN         2
`define CTRL_DB_OFF         3
`define CTRL_RESET          8'h00

`endif

// >>> common/cc_role_pkg.sv
/*
 Types for the CC role block.
 Assumes the defines header is compiled alongside.
*/
package cc_role_pkg;
	typedef enum logic [1:0] {
		ROLE_SINK   = 2'h0,
		ROLE_SOURCE = 2'h1,
		ROLE_DUAL   = 2'h2
	} role_t;

	typedef enum logic [3:0] {
		ST_UNATT  = 4'h1,
		ST_ATT    = 4'h2,
		ST_SOURCE = 4'h4,
		ST_SWAP   = 4'h8
	} port_st_t;

	typedef enum logic [2:0] {
		SAR_CONV1 = 3'h1,
		SAR_CONV2 = 3'h2,
		SAR_DONE  = 3'h4
	} sar_st_t;
endpackage

// >>> hw/cc_role.sv
/*
 Per-port CC role control, fast role swap detection, dead-battery pull-down
 and power-up strap decoding through an 8-bit SAR converter.
 Assumes analog comparators and a SAR comparator output driven from pins,
 all asynchronous, and a simple strobe register port on clk_in.
*/
`timescale 1ns/1ps
`include "cc_role_defines.svh"
//
// Contract
// R1: Sink role applies pull-down and waits for source
// R2: Sink attach declared only with VBUS present
// R3: Advertised current from connected CC level
// R4: Dual role alternates pull-down and pull-up
// R5: Flag swap after CC low for detect time
// R6: Swap disables both gates, enters source
// R7: Dead battery pull-down present by default
// R8: Control removes dead-battery pull-down
// R9: Straps govern response when main supply low
// R10: Convert both straps at power-up
// R11: Straps select address, sink path, configuration
// R12: Low ratio bands decode to 0 to 3
// R13: Middle ratio bands decode to 4 to 6
// R14: Top ratio band decodes to 7
// R15: 8-bit SAR result readable by firmware
// R16: Converter input from selectable mux
// R17: Detach after CC high for debounce
// R18: Strap values captured once, held
// R19: Swap detector idle unless sink enabled
module cc_role (
	input  wire logic       clk_in,         // 40 MHz clock
	input  wire logic       rst_n_in,       // Async reset, low
	input  wire logic       vbus_in,        // VBUS present comparator
	input  wire logic       main_supply_in, // Main supply good
	input  wire logic [1:0] cc_rd_in,       // CC above Rd attach level
	input  wire logic [1:0] cc_lvl15_in,    // CC above 1.5 A level
	input  wire logic [1:0] cc_lvl30_in,    // CC above 3.0 A level
	input  wire logic [1:0] cc_frs_low_in,  // CC below swap threshold
	input  wire logic [1:0] cc_dis_in,      // CC above disconnect level
	input  wire logic       sar_cmp_in,     // SAR comparator result
	input  wire logic [3:0] addr_in,        // Register address
	input  wire logic [7:0] wdata_in,       // Write data
	input  wire logic       wr_in,          // Write strobe
	input  wire logic       rd_in,          // Read strobe
	output logic      [7:0] rdata_out,      // Read data
	output logic      [1:0] sink_pulldown_out,         // Pull-down enables
	output logic      [1:0] source_pullup_current_out, // Pull-up enables
	output logic            system_path_gate_out,      // Sink gate
	output logic            bus_path_gate_out,         // Sink gate
	output logic            attached_out,   // Port attached
	output logic      [1:0] adv_current_out, // Source current level
	output logic            swap_flag_out,  // Swap detected, to core
	output logic      [7:0] sar_dac_out,    // SAR trial code
	output logic      [2:0] sar_mux_out,    // Converter mux select
	output logic      [2:0] slave_addr_out, // Serial port address index
	output logic            db_sink_path_out, // Dead-battery sink path on
	output logic      [2:0] default_cfg_out // Default configuration
);
	localparam int SWAP_N = `SWAP_DETECT_CYC;
	localparam int DET_N  = `DETACH_DEBOUNCE_CYC;
	localparam int TOG_N  = `TOGGLE_HALF_CYC;

	function automatic logic [2:0] strap_decode(input logic [7:0] v);
		if (v <= `STRAP_LIM0) strap_decode = 3'h0;
		else if (v <= `STRAP_LIM1) strap_decode = 3'h1;
		else if (v <= `STRAP_LIM2) strap_decode = 3'h2;
		else if (v <= `STRAP_LIM3) strap_decode = 3'h3;
		else if (v <= `STRAP_LIM4) strap_decode = 3'h4;
		else if (v <= `STRAP_LIM5) strap_decode = 3'h5;
		else if (v <= `STRAP_LIM6) strap_decode = 3'h6;
		else strap_decode = 3'h7;
	endfunction

	// Two-flop synchronisers for all analog comparator inputs
	logic [10:0] sy1_q, sy2_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sy1_q <= 11'h000;
			sy2_q <= 11'h000;
		end else begin
			sy1_q <= {sar_cmp_in, main_supply_in, vbus_in, cc_rd_in,
				cc_lvl15_in, cc_lvl30_in, cc_frs_low_in[0], cc_dis_in[0]};
			sy2_q <= sy1_q;
		end
	end
	logic [1:0] frs_s, dis_s;
	logic [1:0] frs_hi_q, dis_hi_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frs_hi_q <= 2'h0;
			dis_hi_q <= 2'h0;
		end else begin
			frs_hi_q <= {cc_frs_low_in[1], frs_hi_q[1]};
			dis_hi_q <= {cc_dis_in[1], dis_hi_q[1]};
		end
	end
	logic       sar_s, main_s, vbus_s;
	logic [1:0] rd_s, l15_s, l30_s;
	assign {sar_s, main_s, vbus_s, rd_s, l15_s, l30_s} = sy2_q[10:2];
	assign frs_s = {frs_hi_q[0], sy2_q[1]};
	assign dis_s = {dis_hi_q[0], sy2_q[0]};

	// Control register
	logic [7:0] ctrl_q;
	logic [7:0] mux_q;
	cc_role_pkg::role_t role;
	logic frs_en, db_off;
	assign role   = cc_role_pkg::role_t'(ctrl_q[`CTRL_ROLE_LSB +: 2]);
	assign frs_en = ctrl_q[`CTRL_FRS_EN];
	assign db_off = ctrl_q[`CTRL_DB_OFF];

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= `CTRL_RESET;
			mux_q  <= 8'h00;
		end else if (wr_in) begin
			if (addr_in == `ADDR_CTRL) ctrl_q <= wdata_in;
			else if (addr_in == `ADDR_MUX) mux_q <= wdata_in; // R16
		end
	end

	// SAR converter: strap one, strap two, then firmware conversions
	cc_role_pkg::sar_st_t sar_st_q;
	logic [7:0] sar_q, sar_res_q;
	logic [2:0] bit_q;
	logic [1:0] ph_q;
	logic [2:0] strap1_q, strap2_q;
	logic       straps_ok_q;
	logic [7:0] trial;
	assign trial = sar_q | (8'h80 >> bit_q);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sar_st_q    <= cc_role_pkg::SAR_CONV1;
			sar_q       <= 8'h00;
			sar_res_q   <= 8'h00;
			bit_q       <= 3'h0;
			strap1_q    <= 3'h0;
			strap2_q    <= 3'h0;
			straps_ok_q <= 1'b0;
			sar_dac_out <= 8'h80;
			sar_mux_out <= 3'h0;
			ph_q        <= 2'h0;
		end else if (ph_q != `SAR_PHASE_LAST) begin
			// New trial code reaches sar_s only after the synchroniser
			ph_q <= ph_q + 2'h1;
		end else begin
			ph_q <= 2'h0;
			// Comparator high means input at or above trial code
			sar_q <= sar_s ? trial : sar_q; // R15
			if (bit_q == 3'h7) begin
				bit_q     <= 3'h0;
				sar_res_q <= sar_s ? trial : sar_q;
				sar_q     <= 8'h00;
				case (sar_st_q)
				cc_role_pkg::SAR_CONV1: begin
					strap1_q <= strap_decode(sar_s ? trial : sar_q); // R10
					sar_st_q <= cc_role_pkg::SAR_CONV2;
					sar_mux_out <= 3'h1;
				end
				cc_role_pkg::SAR_CONV2: begin
					strap2_q    <= strap_decode(sar_s ? trial : sar_q); // R12 R13 R14
					straps_ok_q <= 1'b1; // R18
					sar_st_q    <= cc_role_pkg::SAR_DONE;
					sar_mux_out <= mux_q[2:0];
				end
				default: sar_mux_out <= mux_q[2:0]; // R16
				endcase
				sar_dac_out <= 8'h80;
			end else begin
				bit_q       <= bit_q + 3'h1;
				sar_dac_out <= (sar_s ? trial : sar_q) | (8'h40 >> bit_q);
			end
		end
	end

	// Strap-derived outputs, refreshed every cycle once both straps are converted
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slave_addr_out   <= 3'h0;
			db_sink_path_out <= 1'b0;
			default_cfg_out  <= 3'h0;
		end else if (straps_ok_q) begin
			slave_addr_out   <= {1'b0, strap1_q[1:0]}; // R11
			// Sink path closes in dead battery unless strap safe-mode
			db_sink_path_out <= !main_s && strap2_q != 3'h0; // R9
			default_cfg_out  <= strap2_q; // R11
		end
	end

	// Port state machine
	cc_role_pkg::port_st_t st_q;
	logic [31:0] swap_cnt_q, det_cnt_q, tog_cnt_q;
	logic        tog_q;
	logic        sink_mode;
	logic        frs_low;
	logic [1:0]  conn_q;
	// Source role keeps the dead-battery pull-down until released
	assign sink_mode = role == cc_role_pkg::ROLE_SINK ||
		(role == cc_role_pkg::ROLE_DUAL && !tog_q) ||
		(role == cc_role_pkg::ROLE_SOURCE && !db_off); // R7 R8
	// Open pin reads below threshold, so watch only the connected one
	assign frs_low = |(frs_s & conn_q); // R5

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tog_cnt_q <= 32'h0;
			tog_q     <= 1'b0;
		end else if (role != cc_role_pkg::ROLE_DUAL || st_q != cc_role_pkg::ST_UNATT) begin
			tog_cnt_q <= 32'h0;
		end else if (tog_cnt_q == 32'(TOG_N - 1)) begin
			tog_cnt_q <= 32'h0;
			tog_q     <= !tog_q; // R4
		end else begin
			tog_cnt_q <= tog_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q          <= cc_role_pkg::ST_UNATT;
			swap_cnt_q    <= 32'h0;
			det_cnt_q     <= 32'h0;
			conn_q        <= 2'h0;
			swap_flag_out <= 1'b0;
		end else begin
			swap_flag_out <= 1'b0;
			case (st_q)
			cc_role_pkg::ST_UNATT: begin
				det_cnt_q  <= 32'h0;
				swap_cnt_q <= 32'h0;
				if (sink_mode && |rd_s && vbus_s) begin
					st_q   <= cc_role_pkg::ST_ATT; // R2
					conn_q <= rd_s;
				end else if (!sink_mode && |rd_s)
					st_q <= cc_role_pkg::ST_SOURCE;
			end
			cc_role_pkg::ST_ATT: begin
				if (frs_en && frs_low) begin // R19
					swap_cnt_q <= swap_cnt_q + 32'h1;
					if (swap_cnt_q == 32'(SWAP_N - 1)) begin
						swap_flag_out <= 1'b1; // R5
						st_q <= cc_role_pkg::ST_SWAP;
					end
				end else
					swap_cnt_q <= 32'h0;
				if (|dis_s) begin
					det_cnt_q <= det_cnt_q + 32'h1;
					if (det_cnt_q == 32'(DET_N - 1))
						st_q <= cc_role_pkg::ST_UNATT; // R17
				end else
					det_cnt_q <= 32'h0;
			end
			cc_role_pkg::ST_SWAP: st_q <= cc_role_pkg::ST_SOURCE; // R6
			cc_role_pkg::ST_SOURCE: begin
				if (!(|rd_s)) st_q <= cc_role_pkg::ST_UNATT;
			end
			default: st_q <= cc_role_pkg::ST_UNATT;
			endcase
		end
	end

	// Pin drives
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Dead-battery pull-down present straight out of reset
			sink_pulldown_out         <= 2'h3; // R7
			source_pullup_current_out <= 2'h0;
			system_path_gate_out      <= 1'b0;
			bus_path_gate_out         <= 1'b0;
			attached_out              <= 1'b0;
			adv_current_out           <= 2'h0;
		end else begin
			if (st_q == cc_role_pkg::ST_SOURCE || st_q == cc_role_pkg::ST_SWAP ||
				(!sink_mode && st_q == cc_role_pkg::ST_UNATT)) begin
				sink_pulldown_out         <= 2'h0;
				source_pullup_current_out <= 2'h3; // R4
			end else begin
				sink_pulldown_out         <= 2'h3; // R1
				source_pullup_current_out <= 2'h0;
			end
			attached_out <= st_q == cc_role_pkg::ST_ATT ||
				st_q == cc_role_pkg::ST_SOURCE;
			system_path_gate_out <= st_q == cc_role_pkg::ST_ATT ||
				(db_sink_path_out && vbus_s && st_q == cc_role_pkg::ST_UNATT); // R6
			bus_path_gate_out    <= st_q == cc_role_pkg::ST_ATT; // R6
			if (st_q == cc_role_pkg::ST_ATT)
				adv_current_out <= |l30_s ? 2'h2 : (|l15_s ? 2'h1 : 2'h0); // R3
			else
				adv_current_out <= 2'h0;
		end
	end

	// Register read port
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) rdata_out <= 8'h00;
		else if (rd_in) begin
			if (addr_in == `ADDR_CTRL) rdata_out <= ctrl_q;
			else if (addr_in == `ADDR_STATUS)
				rdata_out <= {2'h0, straps_ok_q, st_q == cc_role_pkg::ST_SOURCE,
					adv_current_out, vbus_s, attached_out};
			else if (addr_in == `ADDR_STRAP)
				rdata_out <= {1'b0, strap2_q, 1'b0, strap1_q};
			else if (addr_in == `ADDR_SAR) rdata_out <= sar_res_q; // R15
			else if (addr_in == `ADDR_MUX) rdata_out <= mux_q;
			else rdata_out <= 8'h00;
		end else rdata_out <= 8'h00;
	end

	a_swap_needs_sink: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(swap_flag_out) |-> $past(frs_en) && $past(st_q) == cc_role_pkg::ST_ATT)
		else $error("swap flagged outside enabled sink"); // R19
	a_swap_gates_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		swap_flag_out |-> ##[1:3] !bus_path_gate_out && !system_path_gate_out)
		else $error("gates not off after swap"); // R6
	a_swap_to_source: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		swap_flag_out |-> ##1 st_q == cc_role_pkg::ST_SOURCE)
		else $error("source role not taken after swap"); // R6
	a_attach_vbus: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(st_q == cc_role_pkg::ST_ATT) |-> $past(vbus_s))
		else $error("attach without vbus"); // R2
	a_strap_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		straps_ok_q |=> $stable(strap1_q) && $stable(strap2_q) && straps_ok_q)
		else $error("strap values changed"); // R18
	a_sink_pulldown: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		st_q == cc_role_pkg::ST_ATT |=> sink_pulldown_out == 2'h3)
		else $error("pull-down missing while sink attached"); // R1
	a_current_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!attached_out |-> adv_current_out == 2'h0 || $past(st_q) == cc_role_pkg::ST_ATT)
		else $error("current reported while detached"); // R3
	a_role_exclusive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(sink_pulldown_out & source_pullup_current_out) == 2'h0)
		else $error("pull-down and pull-up together"); // R4
	a_db_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		role == cc_role_pkg::ROLE_SOURCE && !db_off &&
		st_q == cc_role_pkg::ST_UNATT |=> sink_pulldown_out == 2'h3)
		else $error("dead-battery pull-down dropped early"); // R8
	c_attach: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(attached_out));
	c_detach: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(attached_out));
	c_swap: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		swap_flag_out);
	c_straps: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(straps_ok_q));
endmodule

// >>> tb/cc_partner.sv
/*
 Behavioural port partner on CC and VBUS, plus the analog side of the
 strap converter: the comparator against the trial code.
 Assumes the bench steers it by plain levels; CC1 is the connected pin.
*/
`timescale 1ns/1ps
module cc_partner (
	input  wire logic       src_in,         // Source pull-up on CC1
	input  wire logic [1:0] lvl_in,         // 0 default, 1 1.5 A, 2 3.0 A
	input  wire logic       vbus_on_in,     // Source drives VBUS
	input  wire logic       frs_in,         // Swap signal pulls CC1 low
	input  wire logic       gone_in,        // CC1 above disconnect
	input  wire logic [7:0] strap1_in,      // Strap one level as code
	input  wire logic [7:0] strap2_in,      // Strap two level as code
	input  wire logic [7:0] aux_in,         // Any other mux input
	input  wire logic [7:0] dac_in,         // SAR trial code
	input  wire logic [2:0] mux_in,         // Mux select
	output logic            vbus_out,       // VBUS present
	output logic      [1:0] cc_rd_out,      // Above attach level
	output logic      [1:0] cc_lvl15_out,   // Above 1.5 A level
	output logic      [1:0] cc_lvl30_out,   // Above 3.0 A level
	output logic      [1:0] cc_frs_low_out, // Below swap threshold
	output logic      [1:0] cc_dis_out,     // Above disconnect
	output logic            cmp_out         // Input at or above trial
);
	logic [7:0] vin;

	assign vbus_out = vbus_on_in;
	assign cc_rd_out = {1'b0, src_in};
	assign cc_lvl15_out = {1'b0, src_in & (lvl_in != 2'h0)};
	assign cc_lvl30_out = {1'b0, src_in & (lvl_in == 2'h2)};
	// Open CC2 sits at ground, so it always reads below threshold
	assign cc_frs_low_out = {1'b1, !src_in | frs_in};
	assign cc_dis_out = {1'b0, gone_in};
	assign vin = (mux_in == 3'h0) ? strap1_in :
		(mux_in == 3'h1) ? strap2_in : aux_in;
	assign cmp_out = vin >= dac_in;
endmodule

// >>> tb/cc_role_bench.sv
/*
 Self-checking bench for the CC role block: straps, converter, attach,
 detach, fast role swap and dead-battery pull-down.
 Assumes the partner model and the block's defines header.
*/
`timescale 1ns/1ps
`include "cc_role_defines.svh"
module cc_role_bench;
	logic       clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       main_supply_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0;
	logic       rd_in = 1'b0;
	logic       src = 1'b0;
	logic       vbus_on = 1'b0;
	logic       frs = 1'b0;
	logic       gone = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic [7:0] s1 = 8'h00;
	logic [7:0] s2 = 8'h00;
	logic [7:0] aux = 8'h5A;
	logic       vbus, sar_cmp, gsys, gbus, att, swap, dbp;
	logic [1:0] cc_rd, cc15, cc30, cc_frs, cc_dis, pd, pu, adv;
	logic [7:0] rdata, dac;
	logic [2:0] mux, sla, cfg;
	int         fails = 0;
	int         checks = 0;
	int         cycles = 0;
	int         swaps = 0;
	logic [7:0] tab [16] = '{8'h05, 8'h06, 8'h12, 8'h13, 8'h24, 8'h25,
		8'h3C, 8'h3D, 8'h5D, 8'h5E, 8'hB4, 8'hB5, 8'hE7, 8'hE8, 8'h00, 8'hFF};
	logic [7:0] lim [7] = '{`STRAP_LIM0, `STRAP_LIM1, `STRAP_LIM2,
		`STRAP_LIM3, `STRAP_LIM4, `STRAP_LIM5, `STRAP_LIM6};

	cc_role DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .vbus_in(vbus),
		.main_supply_in(main_supply_in), .cc_rd_in(cc_rd),
		.cc_lvl15_in(cc15), .cc_lvl30_in(cc30), .cc_frs_low_in(cc_frs),
		.cc_dis_in(cc_dis), .sar_cmp_in(sar_cmp), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata), .sink_pulldown_out(pd),
		.source_pullup_current_out(pu), .system_path_gate_out(gsys),
		.bus_path_gate_out(gbus), .attached_out(att),
		.adv_current_out(adv), .swap_flag_out(swap), .sar_dac_out(dac),
		.sar_mux_out(mux), .slave_addr_out(sla), .db_sink_path_out(dbp),
		.default_cfg_out(cfg));
	cc_partner model (.src_in(src), .lvl_in(lvl), .vbus_on_in(vbus_on),
		.frs_in(frs), .gone_in(gone), .strap1_in(s1), .strap2_in(s2),
		.aux_in(aux), .dac_in(dac), .mux_in(mux), .vbus_out(vbus),
		.cc_rd_out(cc_rd), .cc_lvl15_out(cc15), .cc_lvl30_out(cc30),
		.cc_frs_low_out(cc_frs), .cc_dis_out(cc_dis), .cmp_out(sar_cmp));

	always #12.5 clk_in = ~clk_in;

	// Whole run needs about 5100 cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (swap === 1'b1)
			swaps <= swaps + 1;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata;
	endtask

	function automatic logic [2:0] dec(input logic [7:0] c);
		for (int i = 0; i < 7; i++)
			if (c <= lim[i])
				return 3'(i);
		return 3'h7;
	endfunction

	task automatic boot();
		logic [7:0] st;
		rst_n_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		#1 check("reset pull-down", {6'h0, pd}, 8'h03);
		check("reset gates", {6'h0, gsys, gbus}, 8'h00);
		@(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			reg_rd(`ADDR_STATUS, st);
			if (st[5] === 1'b1)
				break;
		end
		check("straps ready", {7'h0, st[5]}, 8'h01);
	endtask

	// Band edges on both straps, supply low and high alternately
	task automatic t_straps();
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			s1 <= tab[2*i];
			s2 <= tab[2*i+1];
			main_supply_in <= i[0];
			boot();
			reg_rd(`ADDR_STRAP, v);
			check("strap pair", v, {1'b0, dec(s2), 1'b0, dec(s1)});
			check("address index", {5'h0, sla}, {6'h0, 2'(dec(s1))});
			check("default config", {5'h0, cfg}, {5'h0, dec(s2)});
			check("dead sink path", {7'h0, dbp},
				{7'h0, !main_supply_in && dec(s2) != 3'h0});
		end
		@(posedge clk_in);
		s1 <= 8'h40;
		s2 <= 8'h10;
		repeat (80) @(posedge clk_in);
		reg_rd(`ADDR_STRAP, v);
		check("strap held", v, 8'h70);
	endtask

	task automatic t_sar();
		logic [7:0] v;
		reg_wr(`ADDR_MUX, 8'h02);
		repeat (80) @(posedge clk_in);
		reg_rd(`ADDR_SAR, v);
		check("converter result", v, aux);
		reg_rd(`ADDR_MUX, v);
		check("mux select", v, 8'h02);
		reg_rd(4'hF, v);
		check("unmapped read", v, 8'h00);
	endtask

	task automatic attach(input logic [1:0] l);
		@(posedge clk_in);
		src <= 1'b1;
		lvl <= l;
		repeat (20) @(posedge clk_in);
		#1 check("attach without bus", {7'h0, att}, 8'h00);
		check("sink pull-down", {4'h0, pd, pu}, 8'h0C);
		@(posedge clk_in);
		vbus_on <= 1'b1;
		for (int i = 0; i < 20 && att !== 1'b1; i++)
			@(posedge clk_in);
		#1 check("attach", {7'h0, att}, 8'h01);
		check("advertised current", {6'h0, adv}, {6'h0, l});
	endtask

	task automatic t_detach();
		attach(2'h2);
		@(posedge clk_in);
		gone <= 1'b1;
		repeat (`DETACH_DEBOUNCE_CYC - 10) @(posedge clk_in);
		#1 check("early detach", {7'h0, att}, 8'h01);
		// Departing source drops VBUS too, so no instant re-attach
		@(posedge clk_in);
		vbus_on <= 1'b0;
		for (int i = 0; i < 30 && att !== 1'b0; i++)
			@(posedge clk_in);
		#1 check("detach", {7'h0, att}, 8'h00);
		@(posedge clk_in);
		gone <= 1'b0;
		src <= 1'b0;
		repeat (10) @(posedge clk_in);
	endtask

	task automatic pulse_frs(input int n);
		@(posedge clk_in);
		frs <= 1'b1;
		repeat (n) @(posedge clk_in);
		frs <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask

	task automatic t_swap();
		attach(2'h1);
		pulse_frs(10);
		check("swap while disabled", 8'(swaps), 8'h00);
		reg_wr(`ADDR_CTRL, 8'h04);
		pulse_frs(`SWAP_DETECT_CYC - 1);
		check("short swap signal", 8'(swaps), 8'h00);
		pulse_frs(`SWAP_DETECT_CYC + 4);
		check("swap flag", 8'(swaps), 8'h01);
		#1 check("gates off", {6'h0, gsys, gbus}, 8'h00);
		check("source pull-up", {6'h0, pu}, 8'h03);
		pulse_frs(10);
		check("swap in source", 8'(swaps), 8'h01);
	endtask

	task automatic t_dead();
		reg_wr(`ADDR_CTRL, 8'h02);
		repeat (3) @(posedge clk_in);
		#1 check("dual sink half", {4'h0, pd, pu}, 8'h0C);
		reg_wr(`ADDR_CTRL, 8'h01);
		repeat (3) @(posedge clk_in);
		#1 check("dead pull-down kept", {4'h0, pd, pu}, 8'h0C);
		reg_wr(`ADDR_CTRL, 8'h09);
		repeat (3) @(posedge clk_in);
		#1 check("pull-down removed", {4'h0, pd, pu}, 8'h03);
	endtask

	initial begin
		t_straps();
		t_sar();
		t_detach();
		t_swap();
		@(posedge clk_in);
		src <= 1'b0;
		vbus_on <= 1'b0;
		boot();
		t_dead();
		end_of_test();
	end
endmodule
